// File: hdl/iodc_irq_out.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Gap length is 8-bit field, 10 us units, resets zero
// - Zero gap disables, clears counter, releases pending
// - New non-zero gap applies at once, running interval included
// - Restart bit clears counter, starts interval, self-clears
// - During gap, pin withheld and status reads one
// - Master bit ORs enabled sources, ignoring gating
// - Pin enable low holds pin de-asserted
// - Pin enable gates only the pin drive
// - Push-pull polarity zero low, one high
// - Drive-kind zero open-drain, one push-pull
// - Open-drain ignores polarity, asserts low
// - Polarity and drive kind survive soft reset
// - Source counts only when its enable bit set
// - Chip reset restores every field default
module iodc_irq_out #(
  parameter int unsigned NUM_SRC = 32,
  parameter int unsigned GAP_UNIT_CYCLES = iodc_pkg::GAP_UNIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic soft_rst_in,
  input wire logic [NUM_SRC-1:0] src_active_in,
  input wire logic [NUM_SRC-1:0] src_enable_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [iodc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [iodc_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [iodc_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic master_irq_out,
  output logic gap_active_out,
  output logic irq_pin_out,
  output logic irq_pin_oe_out
);

  localparam logic [iodc_pkg::GAP_INTERVAL_W-1:0] GAP_ZERO = '0;

  iodc_pkg::iodc_soft_cfg_s soft_q;
  iodc_pkg::iodc_soft_cfg_s soft_d;
  iodc_pkg::iodc_kept_cfg_s kept_q;
  iodc_pkg::iodc_kept_cfg_s kept_d;
  iodc_pkg::iodc_gap_state_e state_q;
  iodc_pkg::iodc_gap_state_e state_d;
  logic [iodc_pkg::GAP_INTERVAL_W-1:0] units_q;
  logic [iodc_pkg::GAP_INTERVAL_W-1:0] units_d;
  logic [iodc_pkg::DATA_W-1:0] rdata_q;
  logic [iodc_pkg::DATA_W-1:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic master_q;

  logic cfg_hit;
  logic cfg_wr;
  logic restart;
  logic [iodc_pkg::GAP_INTERVAL_W-1:0] new_gap;
  logic tick;
  logic in_gap;
  logic master;
  logic pin_assert;

  assign cfg_hit = (reg_addr_in == iodc_pkg::IRQ_OUTPUT_CONFIG_OFS);
  assign cfg_wr = reg_wr_in && cfg_hit;
  assign new_gap = reg_wdata_in[iodc_pkg::GAP_INTERVAL_LSB +: iodc_pkg::GAP_INTERVAL_W];
  // Restart is a strobe only; nothing stores it, so it reads back zero
  assign restart = cfg_wr && reg_wdata_in[iodc_pkg::GAP_RESTART_BIT];

  assign master = |(src_active_in & src_enable_in);
  assign in_gap = (state_q == iodc_pkg::IODC_GAP);

  // Configuration, soft-resettable part
  always_comb begin
    soft_d = soft_q;
    if (soft_rst_in) begin
      soft_d.gap_interval = iodc_pkg::GAP_INTERVAL_RST;
      soft_d.pin_enable = iodc_pkg::PIN_ENABLE_RST;
    end else if (cfg_wr) begin
      soft_d.gap_interval = new_gap;
      soft_d.pin_enable = reg_wdata_in[iodc_pkg::PIN_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      soft_q.gap_interval <= iodc_pkg::GAP_INTERVAL_RST;
      soft_q.pin_enable <= iodc_pkg::PIN_ENABLE_RST;
    end else begin
      soft_q <= soft_d;
    end
  end

  // Drive configuration ignores soft reset
  always_comb begin
    kept_d = kept_q;
    if (cfg_wr) begin
      kept_d.pin_polarity = reg_wdata_in[iodc_pkg::PIN_POLARITY_BIT];
      kept_d.push_pull = reg_wdata_in[iodc_pkg::PUSH_PULL_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      kept_q.pin_polarity <= iodc_pkg::PIN_POLARITY_RST;
      kept_q.push_pull <= iodc_pkg::PUSH_PULL_RST;
    end else begin
      kept_q <= kept_d;
    end
  end

  iodc_tick #(
    .CYCLES(GAP_UNIT_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(in_gap),
    .restart_in(restart),
    .tick_out(tick)
  );

  // De-assertion gap sequencer
  always_comb begin
    state_d = state_q;
    units_d = units_q;
    unique case (state_q)
      iodc_pkg::IODC_IDLE: begin
        units_d = GAP_ZERO;
        if (master) begin
          state_d = iodc_pkg::IODC_ASSERTED;
        end
      end
      iodc_pkg::IODC_ASSERTED: begin
        units_d = GAP_ZERO;
        // Gap starts when the internal line drops, pin enabled or not
        if (!master) begin
          state_d = (soft_q.gap_interval == GAP_ZERO) ? iodc_pkg::IODC_IDLE
                                                      : iodc_pkg::IODC_GAP;
        end
      end
      iodc_pkg::IODC_GAP: begin
        // Compared live, so a rewritten length takes effect at once
        if (tick) begin
          units_d = units_q + 8'h01;
          if ((units_q + 8'h01) >= soft_q.gap_interval) begin
            state_d = iodc_pkg::IODC_IDLE;
            units_d = GAP_ZERO;
          end
        end
      end
      default: begin
        state_d = iodc_pkg::IODC_IDLE;
        units_d = GAP_ZERO;
      end
    endcase
    if (restart) begin
      state_d = iodc_pkg::IODC_GAP;
      units_d = GAP_ZERO;
    end
    // Zero length wins over restart and releases held interrupts
    if (soft_d.gap_interval == GAP_ZERO) begin
      if (state_d == iodc_pkg::IODC_GAP) begin
        state_d = iodc_pkg::IODC_IDLE;
      end
      units_d = GAP_ZERO;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= iodc_pkg::IODC_IDLE;
      units_q <= GAP_ZERO;
    end else begin
      state_q <= state_d;
      units_q <= units_d;
    end
  end

  // Pin enable masks only here, status paths stay untouched
  assign pin_assert = master && !in_gap && soft_q.pin_enable;

  iodc_pin u_pin (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .assert_in(pin_assert),
    .pin_polarity_in(kept_q.pin_polarity),
    .push_pull_in(kept_q.push_pull),
    .irq_pin_out(irq_pin_out),
    .irq_pin_oe_out(irq_pin_oe_out)
  );

  // Read port; unmapped offsets read zero
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd_in;
    if (reg_rd_in) begin
      rdata_d = iodc_pkg::READ_ZERO;
      if (cfg_hit) begin
        rdata_d[iodc_pkg::GAP_INTERVAL_LSB +: iodc_pkg::GAP_INTERVAL_W] = soft_q.gap_interval;
        rdata_d[iodc_pkg::GAP_ACTIVE_BIT] = in_gap;
        rdata_d[iodc_pkg::MASTER_IRQ_BIT] = master;
        rdata_d[iodc_pkg::PIN_ENABLE_BIT] = soft_q.pin_enable;
        rdata_d[iodc_pkg::PIN_POLARITY_BIT] = kept_q.pin_polarity;
        rdata_d[iodc_pkg::PUSH_PULL_BIT] = kept_q.push_pull;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= iodc_pkg::READ_ZERO;
      rvalid_q <= 1'b0;
      master_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      master_q <= master;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign master_irq_out = master_q;
  assign gap_active_out = in_gap;

endmodule

`default_nettype wire

// File: hdl/iodc_pin.sv
`timescale 1ns/1ps
`default_nettype none

// Final pin stage: drive kind and polarity, registered so the pad never glitches
module iodc_pin (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic assert_in,
  input wire logic pin_polarity_in,
  input wire logic push_pull_in,
  output logic irq_pin_out,
  output logic irq_pin_oe_out
);

  logic o_q;
  logic o_d;
  logic oe_q;
  logic oe_d;

  always_comb begin
    if (push_pull_in) begin
      oe_d = 1'b1;
      o_d = pin_polarity_in ? assert_in : !assert_in;
    end else begin
      // Wired-OR: only ever pull low, polarity has no say
      oe_d = assert_in;
      o_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      o_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      o_q <= o_d;
      oe_q <= oe_d;
    end
  end

  assign irq_pin_out = o_q;
  assign irq_pin_oe_out = oe_q;

endmodule

`default_nettype wire

// File: hdl/iodc_pkg.sv
package iodc_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;

  // Register map
  localparam logic [ADDR_W-1:0] IRQ_OUTPUT_CONFIG_OFS = 10'h054;

  // Field positions inside irq_output_config
  localparam int unsigned GAP_INTERVAL_LSB = 24;
  localparam int unsigned GAP_INTERVAL_W = 8;
  localparam int unsigned GAP_RESTART_BIT = 14;
  localparam int unsigned GAP_ACTIVE_BIT = 13;
  localparam int unsigned MASTER_IRQ_BIT = 12;
  localparam int unsigned PIN_ENABLE_BIT = 8;
  localparam int unsigned PIN_POLARITY_BIT = 4;
  localparam int unsigned PUSH_PULL_BIT = 0;

  // Values after reset
  localparam logic [GAP_INTERVAL_W-1:0] GAP_INTERVAL_RST = 8'h00;
  localparam logic PIN_ENABLE_RST = 1'b0;
  localparam logic PIN_POLARITY_RST = 1'b0;
  localparam logic PUSH_PULL_RST = 1'b0;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // Timing
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned GAP_UNIT_US = 10;
  localparam int unsigned GAP_UNIT_CYCLES = (GAP_UNIT_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned TICK_W = $clog2(GAP_UNIT_CYCLES);

  typedef enum logic [1:0] {
    IODC_IDLE,
    IODC_ASSERTED,
    IODC_GAP
  } iodc_gap_state_e;

  typedef struct packed {
    logic [GAP_INTERVAL_W-1:0] gap_interval;
    logic pin_enable;
  } iodc_soft_cfg_s;

  typedef struct packed {
    logic pin_polarity;
    logic push_pull;
  } iodc_kept_cfg_s;

endpackage

// File: hdl/iodc_tick.sv
`timescale 1ns/1ps
`default_nettype none

// Divider giving one pulse per gap unit; restartable so a fresh interval is full length
module iodc_tick #(
  parameter int unsigned CYCLES = iodc_pkg::GAP_UNIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  input wire logic restart_in,
  output logic tick_out
);

  localparam int unsigned W = $clog2(CYCLES);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  localparam logic [W-1:0] ZERO = '0;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (restart_in || !run_in) begin
      cnt_d = ZERO;
    end else if (cnt_q == LAST) begin
      cnt_d = ZERO;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick_out = run_in && !restart_in && (cnt_q == LAST);

endmodule

`default_nettype wire

// File: tb/iodc_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host interrupt input; board pull-up holds an undriven line high
module iodc_host (
  input wire logic pin_in,
  input wire logic oe_in,
  input wire logic act_high_in,
  output logic level_out,
  output logic seen_out
);
  assign level_out = oe_in ? pin_in : 1'b1;
  assign seen_out = level_out == act_high_in;
endmodule
`default_nettype wire

// File: tb/iodc_irq_out_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module iodc_asserts #(
  parameter int unsigned NUM_SRC = 32,
  parameter int unsigned GAP_UNIT_CYCLES = 1000
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic soft_rst_in,
  input wire logic [NUM_SRC-1:0] src_active_in,
  input wire logic [NUM_SRC-1:0] src_enable_in,
  input wire logic reg_wr_in,
  input wire logic [9:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic master_irq_out,
  input wire logic gap_active_out,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe_out
);
  // Shadow of the config fields, as only ports are visible here
  logic [7:0] ivl_q, ivl_d;
  logic [15:0] cnt_q, cnt_d;
  logic en_q, en_d, pol_q, pol_d, pp_q, pp_d, wr, act;
  always_comb begin
    wr = reg_wr_in && reg_addr_in == iodc_pkg::IRQ_OUTPUT_CONFIG_OFS;
    {ivl_d, en_d, pol_d, pp_d} = {ivl_q, en_q, pol_q, pp_q};
    if (wr) begin
      {ivl_d, en_d, pol_d, pp_d} = {reg_wdata_in[31:24], reg_wdata_in[8],
        reg_wdata_in[4], reg_wdata_in[0]};
    end
    if (soft_rst_in) {ivl_d, en_d} = 9'h000;
    cnt_d = gap_active_out && !(wr && reg_wdata_in[14]) ? cnt_q + 16'h0001 : 16'h0000;
    // Asserted: low when open-drain, polarity level when push-pull
    act = irq_pin_oe_out && irq_pin_out == (pp_q && pol_q);
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) {ivl_q, cnt_q, en_q, pol_q, pp_q} <= '0;
    else {ivl_q, cnt_q, en_q, pol_q, pp_q} <= {ivl_d, cnt_d, en_d, pol_d, pp_d};
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Pin lags config by one edge, so config must be settled first
  sequence off_s; !en_q [*2] ##0 $stable({pp_q, pol_q}); endsequence
  sequence drop_s; !gap_active_out [*3] ##0 (master_irq_out && ivl_q != 8'h00); endsequence
  master_or_a: assert property (
    ##1 master_irq_out == $past(|(src_active_in & src_enable_in))) else $error("master");
  gap_quiet_a: assert property (
    gap_active_out [*2] ##0 $stable({pp_q, pol_q}) |-> !act) else $error("gap pin");
  pin_off_a: assert property (off_s |-> !act) else $error("pin off");
  od_low_a: assert property (!pp_q [*2] |-> !irq_pin_out) else $error("od");
  pol_idle_a: assert property (
    (pp_q && !en_q) [*2] ##0 $stable(pol_q) |-> irq_pin_out != pol_q) else $error("pol");
  gap_start_a: assert property (
    drop_s ##0 !soft_rst_in ##1 !master_irq_out |-> ##[0:2] gap_active_out) else $error("start");
  gap_len_a: assert property (
    gap_active_out && ivl_q != 8'h00 |-> cnt_q <= ivl_q * GAP_UNIT_CYCLES + 3) else $error("len");
  restart_a: assert property (
    wr && reg_wdata_in[14] && ivl_d != 8'h00 |-> ##2 gap_active_out) else $error("restart");
endmodule
bind iodc_irq_out iodc_asserts #(.NUM_SRC(NUM_SRC), .GAP_UNIT_CYCLES(GAP_UNIT_CYCLES))
  u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .soft_rst_in(soft_rst_in),
    .src_active_in(src_active_in), .src_enable_in(src_enable_in), .reg_wr_in(reg_wr_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .master_irq_out(master_irq_out),
    .gap_active_out(gap_active_out), .irq_pin_out(irq_pin_out),
    .irq_pin_oe_out(irq_pin_oe_out));
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0, rst_b_in = 1'b0, soft_rst_in = 1'b0, act_high = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [3:0] src_active_in = 4'h0, src_enable_in = 4'h1;
  logic [9:0] reg_addr_in = 10'h054;
  logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out, rd;
  logic reg_rvalid_out, master_irq_out, gap_active_out, irq_pin_out, irq_pin_oe_out;
  logic level, seen;
  int n_mismatch = 0, checked = 0, cycles = 0;
  // Gap unit cut to 4 cycles to keep intervals short
  iodc_irq_out #(.NUM_SRC(4), .GAP_UNIT_CYCLES(4)) u_dut (.*);
  iodc_host u_host (.pin_in(irq_pin_out), .oe_in(irq_pin_oe_out), .act_high_in(act_high),
    .level_out(level), .seen_out(seen));
  always #5 clk_in = ~clk_in;
  task automatic wrap_up();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    cyc(1);
    reg_addr_in = a;
    reg_wdata_in = d;
    {reg_wr_in, reg_rd_in} = {w, !w};
    cyc(1);
    {reg_wr_in, reg_rd_in} = 2'b00;
    rd = reg_rdata_out;
    if (!w) chk("rvalid", reg_rvalid_out, 1'b1);
  endtask
  task automatic t_master();
    src_active_in = 4'h6;
    acc(0, 10'h054, 32'h0);
    chk("masked", rd[12], 1'b0);
    src_enable_in = 4'h2;
    acc(0, 10'h054, 32'h0);
    chk("master", rd[12], 1'b1);
    chk("master line", master_irq_out, 1'b1);
    chk("pin off", seen, 1'b0);
    acc(1, 10'h054, 32'h0000_0100);
    cyc(1);
    chk("pin on", seen, 1'b1);
    src_active_in = 4'h0;
  endtask
  task automatic t_drive();
    for (int i = 0; i < 4; i++) begin
      acc(1, 10'h054, {27'h0000008, i[1], 3'h0, i[0]});
      act_high = i[0] & i[1];
      src_active_in = 4'h2;
      cyc(2);
      chk("asserted", {level, seen}, {act_high, 1'b1});
      src_active_in = 4'h0;
      cyc(2);
      chk("idle", {level, seen}, {~act_high, 1'b0});
    end
  endtask
  task automatic t_gap(input int k);
    int n;
    src_active_in = 4'h2;
    cyc(2);
    src_active_in = 4'h0;
    n = 0;
    while (!gap_active_out && n < 4) begin
      cyc(1);
      n++;
    end
    // Source comes back inside the gap and must wait
    src_active_in = 4'h2;
    acc(0, 10'h054, 32'h0);
    chk("gap status", rd[13], 1'b1);
    chk("held", seen, 1'b0);
    n = 2;
    while (gap_active_out && n < 40) begin
      cyc(1);
      n++;
    end
    chk("gap length", n >= k * 4 - 1 && n <= k * 4 + 2, 1'b1);
    cyc(2);
    chk("released", seen, 1'b1);
    src_active_in = 4'h0;
    cyc(k * 4 + 4);
  endtask
  task automatic t_restart();
    acc(1, 10'h054, 32'h0300_4101);
    cyc(1);
    chk("restart", gap_active_out, 1'b1);
    src_active_in = 4'h2;
    acc(0, 10'h054, 32'h0);
    chk("restart bits", rd[14:13], 2'b01);
    acc(1, 10'h054, 32'h0000_0101);
    cyc(2);
    chk("zero gap", {gap_active_out, seen}, 2'b01);
    src_active_in = 4'h0;
  endtask
  task automatic t_soft();
    acc(1, 10'h054, 32'h0500_0111);
    soft_rst_in = 1'b1;
    cyc(1);
    soft_rst_in = 1'b0;
    acc(0, 10'h054, 32'h0);
    chk("soft", rd, 32'h0000_0011);
    cyc(3);
    rst_b_in = 1'b0;
    cyc(2);
    rst_b_in = 1'b1;
    acc(0, 10'h054, 32'h0);
    chk("chip", rd, 32'h0);
    acc(0, 10'h058, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  initial begin
    cyc(16);
    rst_b_in = 1'b1;
    t_master();
    t_drive();
    act_high = 1'b0;
    acc(1, 10'h054, 32'h0200_0101);
    t_gap(2);
    acc(1, 10'h054, 32'h0100_0101);
    t_gap(1);
    t_restart();
    t_soft();
    wrap_up();
  end
endmodule
`default_nettype wire
